// ==== retrot_pkg.sv ====
/*
  Shared constants and types for the return and rotate execution block.
  Assumes a core that decodes instructions elsewhere and presents one-hot
  operation strobes plus operands on the instruction clock.
*/
package retrot_pkg;
  localparam int          DATA_W      = 8;
  localparam int          PC_W        = 15;
  localparam int          GLOBAL_IE_BIT = 7;
  localparam int          RET_CYCLES  = 2;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  INTCTL_RESET = 8'h00;
  localparam logic [14:0] PC_RESET    = 15'h0000;
  localparam logic        DEST_ACC    = 1'b0;
  localparam logic        DEST_FILE   = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RET1 = 3'b010,
    ST_RET2 = 3'b100
  } exec_state_t;
endpackage

// ==== return_and_rotate_exec.sv ====
/*
  Execution of the three return instructions and the two rotates.
  Assumes decode raises exactly one op strobe per issued instruction, holds
  issue off while busy_o is high, and that the stack pop is done by the
  stack when pop_o pulses; top_of_stack_i is valid while pop_o is high.
*/
module return_and_rotate_exec
  import retrot_pkg::*;
#(
  parameter int W  = DATA_W,
  parameter int PW = PC_W
) (
  input  wire logic          mclk_i,                    // Instruction clock
  input  wire logic          rstn_i,                    // Async reset, active low
  input  wire logic          ce_i,                      // Clock enable
  input  wire logic          return_from_interrupt_op_i, // Return from interrupt
  input  wire logic          return_op_i,               // Plain return
  input  wire logic          return_with_literal_op_i,  // Return with literal
  input  wire logic          rotate_left_op_i,          // Rotate left
  input  wire logic          rotate_right_op_i,         // Rotate right
  input  wire logic [W-1:0]  literal_i,                 // Immediate operand
  input  wire logic          dest_i,                    // 0 acc, 1 file
  input  wire logic [W-1:0]  file_rdata_i,              // Addressed file value
  input  wire logic [PW-1:0] top_of_stack_i,            // Stack top entry
  output logic               pop_o,                     // Stack pop pulse
  output logic               busy_o,                    // Return in progress
  output logic               file_we_o,                 // File write pulse
  output logic      [W-1:0]  file_wdata_o,              // File write data
  output logic      [W-1:0]  accumulator_o,             // Accumulator
  output logic               carry_o,                   // Carry flag
  output logic      [W-1:0]  interrupt_control_reg_o,   // Interrupt control
  output logic               global_interrupt_enable_o, // Enable bit view
  output logic      [PW-1:0] pc_o,                      // Program counter
  output logic               pc_load_o                  // PC loaded pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  exec_state_t state;
  exec_state_t next_state;
  logic        is_rfi;
  logic        is_rlw;
  logic [W-1:0] lit_hold;

  wire any_ret  = return_from_interrupt_op_i | return_op_i | return_with_literal_op_i;
  wire any_rot  = rotate_left_op_i | rotate_right_op_i;
  wire idle     = (state == ST_IDLE);
  wire ret_go   = idle & any_ret;
  wire rot_go   = idle & any_rot & ~any_ret;
  wire ret_done = (state == ST_RET2);

  ////////////////////////////////////////////////////////////////////////////
  // Rotate datapath
  logic [W-1:0] rot_res;
  logic         rot_c;

  rotate_unit #(.W(W)) rotate_unit_inst (
    .value_i  (file_rdata_i),
    .carry_i  (carry_o),
    .left_i   (rotate_left_op_i),
    .result_o (rot_res),
    .carry_o  (rot_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch slot then pop slot, so a return costs two cycles
  always_comb begin
    case (state)
      ST_IDLE: next_state = ret_go ? ST_RET1 : ST_IDLE;
      ST_RET1: next_state = ST_RET2;
      ST_RET2: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign busy_o = ~idle;
  assign pop_o  = ret_done;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Capture kind and literal at issue; operands need not stay stable
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      is_rfi   <= 1'b0;
      is_rlw   <= 1'b0;
      lit_hold <= '0;
    end else if (ce_i && ret_go) begin
      is_rfi   <= return_from_interrupt_op_i;
      is_rlw   <= return_with_literal_op_i;
      lit_hold <= literal_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_o      <= PC_RESET;
      pc_load_o <= 1'b0;
    end else if (ce_i) begin
      pc_load_o <= ret_done;
      if (ret_done) begin
        pc_o <= top_of_stack_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt control: only interrupt return touches the enable bit
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_control_reg_o <= INTCTL_RESET;
    end else if (ce_i && ret_done && is_rfi) begin
      interrupt_control_reg_o[GLOBAL_IE_BIT] <= 1'b1;
    end
  end
  assign global_interrupt_enable_o = interrupt_control_reg_o[GLOBAL_IE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator, carry and file write; returns never touch carry
  wire rot_to_acc  = rot_go & (dest_i == DEST_ACC);
  wire rot_to_file = rot_go & (dest_i == DEST_FILE);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      accumulator_o <= ACC_RESET;
      carry_o       <= 1'b0;
      file_we_o     <= 1'b0;
      file_wdata_o  <= '0;
    end else if (ce_i) begin
      file_we_o <= rot_to_file;
      if (rot_go) begin
        carry_o <= rot_c;
      end
      if (rot_to_file) begin
        file_wdata_o <= rot_res;
      end
      if (rot_to_acc) begin
        accumulator_o <= rot_res;
      end else if (ret_done && is_rlw) begin
        accumulator_o <= lit_hold;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Cycles since issue; frozen along with the state while ce_i is low
  int unsigned ret_age;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ret_age <= 0;
    end else if (ce_i) begin
      ret_age <= ret_go ? 1 : (busy_o ? ret_age + 1 : 0);
    end
  end

  // Return sequencing; enabled cycles only, since ce_i low stretches a return
  ret_len_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pop_o |-> ret_age == RET_CYCLES) else $error("return not two cycles");
  ret_busy_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && ret_go) |=> busy_o && !pop_o)
    else $error("return not held busy");
  ret_pop_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && ret_go) ##1 ce_i |=> pop_o && busy_o) else $error("no pop");
  pc_load_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && pop_o) |=> pc_o == $past(top_of_stack_i)) else $error("pc not from stack");
  ie_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && pop_o && is_rfi) |=> global_interrupt_enable_o) else $error("enable not set");
  ie_keep_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && pop_o && !is_rfi) |=> $stable(interrupt_control_reg_o)) else $error("ctl changed");
  lit_acc_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && ret_go && return_with_literal_op_i) ##1 ce_i ##1 ce_i |=>
      accumulator_o == $past(literal_i, 3))
    else $error("literal not loaded");
  ret_carry_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && pop_o && is_rlw) |=> $stable(carry_o) && $stable(interrupt_control_reg_o))
    else $error("flags changed on literal return");
  ret_keep_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && pop_o && !is_rlw) |=> $stable(accumulator_o) && $stable(carry_o))
    else $error("state changed on return");
  ret_refuse_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && busy_o) |=> !file_we_o && $stable(carry_o))
    else $error("rotate taken while busy");

  // Rotate results, destination and timing
  rotl_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go && rotate_left_op_i) |=>
      carry_o == $past(file_rdata_i[W-1])) else $error("left carry wrong");
  rotl_acc_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go && rotate_left_op_i && !dest_i) |=>
      accumulator_o == {$past(file_rdata_i[W-2:0]), $past(carry_o)})
    else $error("left rotate wrong");
  rotr_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go && !rotate_left_op_i && dest_i) |=>
      file_we_o && file_wdata_o == {$past(carry_o), $past(file_rdata_i[W-1:1])})
    else $error("right rotate wrong");
  rotr_acc_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go && !rotate_left_op_i && !dest_i) |=>
      accumulator_o == {$past(carry_o), $past(file_rdata_i[W-1:1])})
    else $error("right rotate to accumulator wrong");
  dest_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go && !dest_i) |=> !file_we_o) else $error("file written for acc dest");
  acc_keep_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go && dest_i) |=> $stable(accumulator_o))
    else $error("accumulator changed for file dest");
  rot_one_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && rot_go) |=> !busy_o && file_we_o == $past(dest_i) && $stable(pc_o)
      && $stable(interrupt_control_reg_o)) else $error("rotate not single cycle");

  rfi_c: cover property (@(posedge mclk_i) ce_i && pop_o && is_rfi);
  rlw_c: cover property (@(posedge mclk_i) ce_i && pop_o && is_rlw);
  rotf_c: cover property (@(posedge mclk_i) ce_i && rot_to_file);
  rota_c: cover property (@(posedge mclk_i) ce_i && rot_to_acc);
  rot_pair_c: cover property (@(posedge mclk_i) ce_i && rot_go ##1 ce_i && rot_go);
endmodule

// ==== return_and_rotate_exec_test.sv ====
/*
  Self-checking bench for the return and rotate execution block.
  Assumes the block's own assertions and covers sit in the design files;
  the bench plays decode and the stack, driving inputs at the falling edge.
*/
module return_and_rotate_exec_test
  import retrot_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk_i, rstn_i, ce_i, rfi_op, ret_op, lit_op, rl_op, rr_op, dest;
  logic [7:0]  lit, fdat, fwd, acc, icr;
  logic [14:0] stack_top, pc;
  logic        pop, busy, fwe, cy, int_en, pcl;
  int          miscompares = 0;
  int          num_checks  = 0;

  `define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

  return_and_rotate_exec return_and_rotate_exec_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .return_from_interrupt_op_i(rfi_op), .return_op_i(ret_op),
    .return_with_literal_op_i(lit_op), .rotate_left_op_i(rl_op),
    .rotate_right_op_i(rr_op), .literal_i(lit), .dest_i(dest), .file_rdata_i(fdat),
    .top_of_stack_i(stack_top), .pop_o(pop), .busy_o(busy), .file_we_o(fwe),
    .file_wdata_o(fwd), .accumulator_o(acc), .carry_o(cy),
    .interrupt_control_reg_o(icr), .global_interrupt_enable_o(int_en), .pc_o(pc),
    .pc_load_o(pcl));

  // 10 MHz instruction clock
  always #50 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////
  // One return issue; a rotate offered while busy must be dropped
  task automatic do_ret(input int k, input logic [7:0] l, input logic [14:0] t);
    @(negedge mclk_i);
    rfi_op = (k == 0);
    ret_op = (k == 1);
    lit_op = (k == 2);
    lit = l;
    stack_top = ~t; // Stack top not valid yet, so show garbage
    @(negedge mclk_i);
    {rfi_op, ret_op, lit_op} = 3'b000;
    lit = ~l;
    rl_op = 1'b1;
    fdat = 8'h80;
    `CHK("busy c1", 1'b1, busy)
    `CHK("pop c1", 1'b0, pop)
    @(negedge mclk_i);
    rl_op = 1'b0;
    stack_top = t;
    `CHK("pop c2", 1'b1, pop)
    `CHK("busy c2", 1'b1, busy)
    @(negedge mclk_i);
    stack_top = ~t;
    `CHK("busy c3", 1'b0, busy)
    `CHK("pc load", 1'b1, pcl)
    `CHK("pc", t, pc)
  endtask

  // One rotate; operands scrambled once taken
  task automatic do_rot(input logic left, input logic [7:0] f, input logic d);
    @(negedge mclk_i);
    rl_op = left;
    rr_op = !left;
    fdat = f;
    dest = d;
    @(negedge mclk_i);
    {rl_op, rr_op} = 2'b00;
    fdat = ~f;
    dest = ~d;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_int_return;
    do_ret(0, 8'h5a, 15'h7fff);
    `CHK("int en", 1'b1, int_en)
    `CHK("intctl", 8'h80, icr)
    `CHK("carry kept", 1'b0, cy)
  endtask

  task automatic test_rotate;
    do_rot(1'b1, 8'he6, DEST_ACC);
    `CHK("rl acc", 8'hcc, acc)
    `CHK("rl carry", 1'b1, cy)
    `CHK("rl no write", 1'b0, fwe)
    do_rot(1'b0, 8'h01, DEST_FILE);
    `CHK("rr wdata", 8'h80, fwd)
    `CHK("rr write", 1'b1, fwe)
    `CHK("rr acc kept", 8'hcc, acc)
    `CHK("rr carry", 1'b1, cy)
    do_rot(1'b0, 8'h02, DEST_ACC);
    `CHK("rr acc", 8'h81, acc)
    `CHK("rr carry0", 1'b0, cy)
    `CHK("rot intctl", 8'h80, icr)
  endtask

  task automatic test_return;
    do_ret(1, 8'h33, 15'h2aaa);
    `CHK("ret int en", 1'b1, int_en)
    `CHK("ret carry", 1'b0, cy)
    `CHK("ret acc", 8'h81, acc)
  endtask

  task automatic test_lit_return;
    do_ret(2, 8'hff, 15'h0001);
    `CHK("lit acc", 8'hff, acc)
    `CHK("lit carry", 1'b0, cy)
    `CHK("lit int en", 1'b1, int_en)
  endtask

  // Clock enable low must freeze everything
  task automatic test_freeze;
    ce_i = 1'b0;
    do_rot(1'b1, 8'hff, DEST_FILE);
    `CHK("frz carry", 1'b0, cy)
    `CHK("frz write", 1'b0, fwe)
    ce_i = 1'b1;
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk_i, rstn_i, rfi_op, ret_op, lit_op, rl_op, rr_op, dest} = '0;
    ce_i = 1'b1;
    lit = 8'h00;
    fdat = 8'h00;
    stack_top = 15'h0000;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    rstn_i = 1'b1;
    test_int_return();
    test_rotate();
    test_return();
    test_lit_return();
    test_freeze();
    end_sim();
  end

  // Tests need about 24 cycles; allow over eighty times that
  initial begin
    #(2000 * 100);
    miscompares++;
    end_sim();
  end
endmodule

// ==== rotate_unit.sv ====
/*
  Combinational rotate-through-carry datapath.
  Assumes the caller registers the result and picks the destination.
*/
module rotate_unit
  import retrot_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic [W-1:0] value_i,  // File register contents
  input  wire logic         carry_i,  // Current carry flag
  input  wire logic         left_i,   // High rotates left
  output logic      [W-1:0] result_o, // Rotated value
  output logic              carry_o   // New carry
);
  // Carry acts as a ninth bit in both directions
  assign result_o = left_i ? {value_i[W-2:0], carry_i}
                           : {carry_i, value_i[W-1:1]};
  assign carry_o  = left_i ? value_i[W-1] : value_i[0];
endmodule
